// file: design/cache_clock_hole_config_regs.sv
// Chipset control register three, hole 1 configuration and the logic they steer.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "cache_hole_defs.svh"
// What this block does
// - Block L2 writes to top BIOS segment when shadowed and protect bit set.
// - In slow mode raise bus hold on every second refresh cycle.
// - In write-through mode ignore the CPU hit-modified snoop input.
// - In write-back mode sample hit-modified during snoops and allow burst writes.
// - Write-back mode: flush first, then cache enable and management interrupt, await ack.
// - Clock select picks synchronous bus clock or oscillator over two.
// - In power management mode expansion clock is always oscillator over two.
// - Type field at bits 7 and 4 selects ISA, ROM, none or DRAM.
// - Size field at bits 6:5 selects 64KB, 128KB, 256KB or 1MB.
// - Bit 3 selects legacy or enhanced DRAM bank mapping.
// - On first revision the map select bit reads back as zero.
// - Bits 2:0 hold hole start address bits 26 to 24.
// - Hole start aligns to size; low address bits are ignored.
module cache_clock_hole_config_regs #(
   parameter int SYNC_DIV_W = 2,                // Width of the synchronous divisor field
   parameter logic FIRST_REVISION = 1'b0        // Arbitrary default; set for first silicon
) (
   input wire logic REF_CLK_I,                  // CPU bus clock, 100 MHz
   input wire logic RSTN_I,                     // Asynchronous reset, active low
   input wire logic PSEL_I,                     // APB select
   input wire logic PENABLE_I,                  // APB access phase
   input wire logic PWRITE_I,                   // APB direction
   input wire logic [11:0] PADDR_I,             // APB byte address
   input wire logic [31:0] PWDATA_I,            // APB write data
   output logic [31:0] PRDATA_O,                // APB read data
   output logic PREADY_O,                       // APB ready
   output logic PSLVERR_O,                      // APB error on unmapped address
   input wire logic BIOS_SHADOWED_I,            // Top BIOS segment is shadowed
   input wire logic CPU_WRITE_I,                // Current CPU cycle is a write
   input wire logic [26:16] CPU_ADDR_I,         // Current CPU address bits
   input wire logic REFRESH_I,                  // One-cycle pulse per refresh
   input wire logic SNOOP_I,                    // Snoop cycle in progress
   input wire logic CPU_HIT_MODIFIED_N_I,       // CPU hit-modified, active low
   input wire logic BASE_OSCILLATOR_I,          // Oscillator sampled as a level
   input wire logic SYNC_CLK_I,                 // Synchronous bus clock source
   input wire logic PWR_MGMT_MODE_I,            // Power management mode active
   input wire logic SMM_REQUEST_I,              // Pulse: request entry to management mode
   input wire logic MGMT_ACTIVE_ACK_N_I,        // CPU management-active ack, active low
   output logic L2_WRITE_BLOCK_O,               // Block L2 write for this cycle
   output logic BUS_HOLD_O,                     // Bus hold request for throttling
   output logic SNOOP_HIT_O,                    // Snoop hit a modified line
   output logic BURST_WRITE_EN_O,               // Burst writes permitted
   output logic CPU_FLUSH_N_O,                  // Cache flush to CPU, active low
   output logic CPU_CACHE_ENABLE_N_O,           // Cache enable to CPU, active low
   output logic MGMT_INTERRUPT_N_O,             // Management interrupt, active low
   output logic EXPANSION_BUS_CLOCK_O,          // Expansion bus clock
   output logic ENHANCED_MAP_O,                 // Enhanced DRAM mapping selected
   output logic HOLE_HIT_ISA_O,                 // Access steered to ISA bus
   output logic HOLE_HIT_ROM_O,                 // Access steered to ROM
   output logic HOLE_HIT_DRAM_NC_O              // Access to DRAM, not cacheable
);

   initial
   begin
      if (SYNC_DIV_W < 1 || SYNC_DIV_W > 4)
         $error("SYNC_DIV_W must lie between 1 and 4");
   end

   // ****************************************
   // Register bus
   // ****************************************
   logic [7:0] ctrl3_r;
   logic [7:0] hole1_r;
   logic [7:0] hole1_lo_r;
   logic [SYNC_DIV_W-1:0] sync_div_r;
   cache_hole_pkg::smm_state_type smm_state_r;
   cache_hole_pkg::smm_state_type smm_state_nxt;
   logic access_w;
   logic mapped_w;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == `CTRL3_ADDR) || (a == `HOLE1_ADDR) || (a == `HOLE1_LO_ADDR) ||
         (a == `STATUS_ADDR);
   endfunction : is_mapped

   assign access_w = PSEL_I && PENABLE_I && !PREADY_O;
   assign mapped_w = is_mapped(PADDR_I);

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         ctrl3_r <= `CTRL3_RESET;
         hole1_r <= `HOLE1_RESET;
         hole1_lo_r <= `HOLE1_LO_RESET;
         sync_div_r <= '0;
      end
      // Writes land on the completing edge, the one at which ready is seen high.
      else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I)
      begin
         if (PADDR_I == `CTRL3_ADDR)
            ctrl3_r <= PWDATA_I[7:0];
         if (PADDR_I == `HOLE1_ADDR)
            hole1_r <= PWDATA_I[7:0];
         if (PADDR_I == `HOLE1_LO_ADDR)
            hole1_lo_r <= PWDATA_I[7:0];
         if (PADDR_I == `STATUS_ADDR)
            sync_div_r <= PWDATA_I[SYNC_DIV_W-1:0];
      end
   end

   // One wait state: ready rises in the second access cycle, then drops.
   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
      end
      else
      begin
         PREADY_O <= access_w;
         PSLVERR_O <= access_w && !mapped_w;
         PRDATA_O <= 32'h0000_0000;
         if (access_w && !PWRITE_I)
         begin
            case (PADDR_I)
               `CTRL3_ADDR: PRDATA_O <= {24'h00_0000, ctrl3_r};
               `HOLE1_ADDR: PRDATA_O <= {24'h00_0000, hole1_r[7:4],
                  hole1_r[`HT_MAPNEW_BIT] & ~FIRST_REVISION, hole1_r[2:0]};
               `HOLE1_LO_ADDR: PRDATA_O <= {24'h00_0000, hole1_lo_r};
               `STATUS_ADDR: PRDATA_O <= {20'h0_0000, 2'b00, smm_state_r,
                  4'h0, {(4-SYNC_DIV_W){1'b0}}, sync_div_r};
               default: PRDATA_O <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************
   // Cache protection and throttling
   // ****************************************
   logic in_bios_w;
   logic refresh_odd_r;
   assign in_bios_w = (CPU_ADDR_I[26:20] == 7'h00) && (CPU_ADDR_I[19:16] == 4'hF);

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
         L2_WRITE_BLOCK_O <= 1'b0;
      else
         L2_WRITE_BLOCK_O <= BIOS_SHADOWED_I && ctrl3_r[`C3_L2WP_BIT] && CPU_WRITE_I &&
            in_bios_w;
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         refresh_odd_r <= 1'b0;
         BUS_HOLD_O <= 1'b0;
      end
      else
      begin
         if (REFRESH_I)
            refresh_odd_r <= ~refresh_odd_r;
         BUS_HOLD_O <= REFRESH_I && refresh_odd_r && !ctrl3_r[`C3_TURBO_BIT];
      end
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         SNOOP_HIT_O <= 1'b0;
         BURST_WRITE_EN_O <= 1'b0;
      end
      else
      begin
         SNOOP_HIT_O <= !ctrl3_r[`C3_L1WT_BIT] && SNOOP_I && !CPU_HIT_MODIFIED_N_I;
         BURST_WRITE_EN_O <= !ctrl3_r[`C3_L1WT_BIT];
      end
   end

   // ****************************************
   // Management mode entry
   // ****************************************
   // The flush is held a few cycles so the CPU sees it before the interrupt.
   logic [2:0] flush_cnt_r;

   always_comb
   begin
      smm_state_nxt = smm_state_r;
      case (smm_state_r)
         cache_hole_pkg::SMM_IDLE:
            if (SMM_REQUEST_I)
               smm_state_nxt = ctrl3_r[`C3_L1WT_BIT] ? cache_hole_pkg::SMM_REQ :
                  cache_hole_pkg::SMM_FLUSH;
         cache_hole_pkg::SMM_FLUSH:
            if (flush_cnt_r == 3'(`SMM_FLUSH_CYCLES - 1))
               smm_state_nxt = cache_hole_pkg::SMM_REQ;
         cache_hole_pkg::SMM_REQ:
            smm_state_nxt = cache_hole_pkg::SMM_WAIT;
         cache_hole_pkg::SMM_WAIT:
            if (!MGMT_ACTIVE_ACK_N_I)
               smm_state_nxt = cache_hole_pkg::SMM_IDLE;
         default:
            smm_state_nxt = cache_hole_pkg::SMM_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         smm_state_r <= cache_hole_pkg::SMM_IDLE;
         flush_cnt_r <= 3'b000;
         CPU_FLUSH_N_O <= 1'b1;
         CPU_CACHE_ENABLE_N_O <= 1'b1;
         MGMT_INTERRUPT_N_O <= 1'b1;
      end
      else
      begin
         smm_state_r <= smm_state_nxt;
         flush_cnt_r <= (smm_state_nxt == cache_hole_pkg::SMM_FLUSH &&
            smm_state_r == cache_hole_pkg::SMM_FLUSH) ? flush_cnt_r + 3'b001 : 3'b000;
         CPU_FLUSH_N_O <= !(smm_state_nxt == cache_hole_pkg::SMM_FLUSH);
         CPU_CACHE_ENABLE_N_O <= !(smm_state_nxt == cache_hole_pkg::SMM_REQ ||
            smm_state_nxt == cache_hole_pkg::SMM_WAIT);
         MGMT_INTERRUPT_N_O <= !(smm_state_nxt == cache_hole_pkg::SMM_REQ ||
            smm_state_nxt == cache_hole_pkg::SMM_WAIT);
      end
   end

   // ****************************************
   // Expansion bus clock
   // ****************************************
   logic osc_half_r;
   logic osc_prev_r;

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         osc_prev_r <= 1'b0;
         osc_half_r <= 1'b0;
         EXPANSION_BUS_CLOCK_O <= 1'b0;
      end
      else
      begin
         osc_prev_r <= BASE_OSCILLATOR_I;
         if (BASE_OSCILLATOR_I && !osc_prev_r)
            osc_half_r <= ~osc_half_r;
         EXPANSION_BUS_CLOCK_O <= (ctrl3_r[`C3_ATSYNC_BIT] && !PWR_MGMT_MODE_I) ?
            SYNC_CLK_I : osc_half_r;
      end
   end

   // ****************************************
   // Hole decode
   // ****************************************
   logic [1:0] hole_kind_w;
   logic [10:0] hole_mask_w;
   logic hole_hit_w;

   function automatic logic [10:0] size_mask(input logic [1:0] sz);
      case (sz)
         2'b00: size_mask = 11'h7FF;
         2'b01: size_mask = 11'h7FE;
         2'b10: size_mask = 11'h7FC;
         default: size_mask = 11'h7F0;
      endcase
   endfunction : size_mask

   assign hole_kind_w = {hole1_r[`HT_TYPE_HI_BIT], hole1_r[`HT_TYPE_LO_BIT]};
   assign hole_mask_w = size_mask(hole1_r[6:5]);
   assign hole_hit_w = ((CPU_ADDR_I ^ {hole1_r[2:0], hole1_lo_r}) & hole_mask_w) == 11'h000;

   always_ff @(posedge REF_CLK_I or negedge RSTN_I)
   begin
      if (!RSTN_I)
      begin
         HOLE_HIT_ISA_O <= 1'b0;
         HOLE_HIT_ROM_O <= 1'b0;
         HOLE_HIT_DRAM_NC_O <= 1'b0;
         ENHANCED_MAP_O <= 1'b0;
      end
      else
      begin
         HOLE_HIT_ISA_O <= hole_hit_w && hole_kind_w == cache_hole_pkg::HOLE_ISA;
         HOLE_HIT_ROM_O <= hole_hit_w && hole_kind_w == cache_hole_pkg::HOLE_ROM;
         HOLE_HIT_DRAM_NC_O <= hole_hit_w && hole_kind_w == cache_hole_pkg::HOLE_DRAM;
         ENHANCED_MAP_O <= hole1_r[`HT_MAPNEW_BIT];
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence smm_flush_seq;
      !CPU_FLUSH_N_O && MGMT_INTERRUPT_N_O;
   endsequence

   sequence smm_req_seq;
      CPU_FLUSH_N_O && !MGMT_INTERRUPT_N_O && !CPU_CACHE_ENABLE_N_O;
   endsequence

   AST_L2_BLOCK: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      L2_WRITE_BLOCK_O |-> $past(ctrl3_r[`C3_L2WP_BIT]) && $past(BIOS_SHADOWED_I))
      else $error("L2 write blocked without protection");
   AST_HOLD_SLOW: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      BUS_HOLD_O |-> $past(REFRESH_I) && !$past(ctrl3_r[`C3_TURBO_BIT]))
      else $error("Bus hold outside slow refresh");
   AST_WT_IGNORE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      $past(ctrl3_r[`C3_L1WT_BIT]) |-> !SNOOP_HIT_O)
      else $error("Hit-modified sampled in write-through mode");
   AST_WB_SAMPLE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      !ctrl3_r[`C3_L1WT_BIT] && SNOOP_I && !CPU_HIT_MODIFIED_N_I |=> SNOOP_HIT_O)
      else $error("Snoop hit lost in write-back mode");
   AST_FLUSH_FIRST: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      $fell(MGMT_INTERRUPT_N_O) && !ctrl3_r[`C3_L1WT_BIT] |-> $past(!CPU_FLUSH_N_O))
      else $error("Interrupt without preceding flush");
   AST_SMM_ORDER: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      smm_flush_seq ##1 CPU_FLUSH_N_O |-> smm_req_seq)
      else $error("Flush release not followed by cache enable and interrupt");
   AST_PM_CLOCK: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      $past(PWR_MGMT_MODE_I) |-> EXPANSION_BUS_CLOCK_O == $past(osc_half_r))
      else $error("Expansion clock not oscillator half in power mode");
   AST_NO_HOLE: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      $past(hole_kind_w) == cache_hole_pkg::HOLE_NONE |->
      !HOLE_HIT_ISA_O && !HOLE_HIT_ROM_O && !HOLE_HIT_DRAM_NC_O)
      else $error("Hole decoded while disabled");
   AST_MAP_SEL: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      ENHANCED_MAP_O == $past(hole1_r[`HT_MAPNEW_BIT]))
      else $error("Map select does not follow bit 3");
   AST_HIT_ONEHOT: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
      $onehot0({HOLE_HIT_ISA_O, HOLE_HIT_ROM_O, HOLE_HIT_DRAM_NC_O}))
      else $error("Hole access steered to more than one target");

endmodule : cache_clock_hole_config_regs

// file: pkg/cache_hole_defs.svh
// Register offsets, field positions, reset values and timing counts of the configuration bank.
`ifndef CACHE_HOLE_DEFS_SVH
`define CACHE_HOLE_DEFS_SVH
`define CTRL3_OFFSET 8'h27
`define HOLE1_IDX 8'h28
`define HOLE1_ADDR_IDX 8'h29
`define CTRL3_ADDR 12'h09C
`define HOLE1_ADDR 12'h0A0
`define HOLE1_LO_ADDR 12'h0A4
`define STATUS_ADDR 12'h0A8
`define CTRL3_RESET 8'hDF
`define HOLE1_RESET 8'hE0
`define HOLE1_LO_RESET 8'h00
`define C3_L2WP_BIT 4
`define C3_TURBO_BIT 3
`define C3_L1WT_BIT 2
`define C3_ATSYNC_BIT 1
`define HT_TYPE_HI_BIT 7
`define HT_TYPE_LO_BIT 4
`define HT_MAPNEW_BIT 3
`define SMM_FLUSH_CYCLES 4
`endif

// file: pkg/cache_hole_pkg.sv
// Types shared by the configuration bank.
package cache_hole_pkg;
   typedef enum logic [1:0] {HOLE_ISA = 2'b00, HOLE_ROM = 2'b01, HOLE_NONE = 2'b10,
      HOLE_DRAM = 2'b11} hole_kind_type;
   typedef enum logic [1:0] {SMM_IDLE = 2'b00, SMM_FLUSH = 2'b01, SMM_REQ = 2'b10,
      SMM_WAIT = 2'b11} smm_state_type;
endpackage : cache_hole_pkg

// file: verification/cpu_side_model.sv
// CPU side model: management acknowledge and the hit-modified snoop line.
`timescale 1ns/1ps
module cpu_side_model (
   input wire logic clk_i,         // Bus clock
   input wire logic rstn_i,        // Reset, active low
   input wire logic mgmt_n_i,      // Management interrupt, active low
   input wire logic [3:0] delay_i, // Cycles before acknowledging
   input wire logic hit_i,         // Report a modified line
   input wire logic float_i,       // Leave the hit line undriven
   output logic ack_n_o,           // Management-active acknowledge
   output logic hit_n_o            // Hit-modified, active low
);
   logic [3:0] cnt_r;
   logic wig_r;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cnt_r <= 4'h0;
         ack_n_o <= 1'b1;
      end
      else if (mgmt_n_i)
      begin
         cnt_r <= 4'h0;
         ack_n_o <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 4'h1;
         ack_n_o <= (cnt_r < delay_i);
      end
   end
   // An undriven line wanders every cycle, so a design that listens will see it.
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         wig_r <= 1'b0;
      else
         wig_r <= !wig_r;
   end
   assign hit_n_o = float_i ? wig_r : !hit_i;
endmodule : cpu_side_model

// file: verification/cache_clock_hole_config_regs_tb.sv
// Self-checking bench for the cache, clock and hole configuration bank.
`timescale 1ns/1ps
`include "cache_hole_defs.svh"
module cache_clock_hole_config_regs_tb;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr, pready;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic shad = 1'b0, cwr = 1'b0, refr = 1'b0, snp = 1'b0, osc = 1'b0, sclk = 1'b0;
   logic pm = 1'b0, sreq = 1'b0, hit = 1'b0, flt = 1'b0, ack_n, hit_n;
   logic [26:16] caddr = 11'h000;
   logic [3:0] dly = 4'h1;
   logic blk, hold, snhit, burst, fl_n, ce_n, mi_n, xclk, emap, h_isa, h_rom, h_dram;
   int fails = 0, comparisons = 0;
   always #5 clk = ~clk;
   cache_clock_hole_config_regs uut (.REF_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr), .BIOS_SHADOWED_I(shad),
      .CPU_WRITE_I(cwr), .CPU_ADDR_I(caddr), .REFRESH_I(refr), .SNOOP_I(snp),
      .CPU_HIT_MODIFIED_N_I(hit_n), .BASE_OSCILLATOR_I(osc), .SYNC_CLK_I(sclk),
      .PWR_MGMT_MODE_I(pm), .SMM_REQUEST_I(sreq), .MGMT_ACTIVE_ACK_N_I(ack_n),
      .L2_WRITE_BLOCK_O(blk), .BUS_HOLD_O(hold), .SNOOP_HIT_O(snhit),
      .BURST_WRITE_EN_O(burst), .CPU_FLUSH_N_O(fl_n), .CPU_CACHE_ENABLE_N_O(ce_n),
      .MGMT_INTERRUPT_N_O(mi_n), .EXPANSION_BUS_CLOCK_O(xclk), .ENHANCED_MAP_O(emap),
      .HOLE_HIT_ISA_O(h_isa), .HOLE_HIT_ROM_O(h_rom), .HOLE_HIT_DRAM_NC_O(h_dram));
   cpu_side_model cpu (.clk_i(clk), .rstn_i(rstn), .mgmt_n_i(mi_n), .delay_i(dly),
      .hit_i(hit), .float_i(flt), .ack_n_o(ack_n), .hit_n_o(hit_n));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic test_done;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   // Waits n edges, then lets that edge's updates settle before sampling.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      @(posedge clk) psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) pen <= 1'b1;
      repeat (20)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (pready !== 1'b1)
      begin
         fails++;
         test_done();
      end
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, {24'h00_0000, d}, rd, er);
   endtask : wr
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp,
      input logic eexp);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0000_0000, rd, er);
      chk(nm, rd, exp);
      chk("slave error", {31'h0000_0000, er}, {31'h0000_0000, eexp});
   endtask : rdc
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      rdc("ctrl3", `CTRL3_ADDR, 32'h0000_00DF, 1'b0);
      rdc("hole1", `HOLE1_ADDR, 32'h0000_00E0, 1'b0);
      rdc("hole lo", `HOLE1_LO_ADDR, 32'h0000_0000, 1'b0);
      rdc("unmapped", 12'h0FC, 32'h0000_0000, 1'b1);
      wr(`STATUS_ADDR, 8'h03);
      rdc("status", `STATUS_ADDR, 32'h0000_0003, 1'b0);
      wr(`HOLE1_ADDR, 8'h08);
      rdc("hole1 map", `HOLE1_ADDR, 32'h0000_0008, 1'b0);
      chk("enhanced map", emap, 1'b1);
   endtask : t_regs
   task automatic t_l2;
      for (int wp = 0; wp < 2; wp++)
      begin
         wr(`CTRL3_ADDR, (wp == 1) ? 8'hFF : 8'hEF);
         @(posedge clk) shad <= 1'b1;
         cwr <= 1'b1;
         caddr <= 11'h00F;
         tick(2);
         chk("l2 block", blk, (wp == 1));
      end
      @(posedge clk) caddr <= 11'h010;
      tick(2);
      chk("l2 block outside", blk, 1'b0);
   endtask : t_l2
   task automatic t_turbo;
      for (int m = 0; m < 2; m++)
      begin
         int cnt;
         cnt = 0;
         wr(`CTRL3_ADDR, (m == 1) ? 8'hFF : 8'hF7);
         repeat (4)
         begin
            @(posedge clk) refr <= 1'b1;
            @(posedge clk) refr <= 1'b0;
            #1;
            repeat (3)
            begin
               if (hold === 1'b1)
                  cnt++;
               tick(1);
            end
         end
         chk("hold count", cnt, (m == 1) ? 0 : 2);
      end
   endtask : t_turbo
   task automatic t_snoop;
      wr(`CTRL3_ADDR, 8'hFB);
      @(posedge clk) snp <= 1'b1;
      hit <= 1'b1;
      tick(2);
      chk("snoop hit wb", snhit, 1'b1);
      chk("burst wb", burst, 1'b1);
      wr(`CTRL3_ADDR, 8'hFF);
      @(posedge clk) flt <= 1'b1;
      repeat (4)
      begin
         tick(1);
         chk("snoop hit wt", snhit, 1'b0);
      end
      chk("burst wt", burst, 1'b0);
      @(posedge clk) snp <= 1'b0;
      flt <= 1'b0;
   endtask : t_snoop
   task automatic t_smm;
      for (int m = 0; m < 2; m++)
      begin
         int cnt;
         cnt = 0;
         wr(`CTRL3_ADDR, (m == 1) ? 8'hFF : 8'hFB);
         @(posedge clk) dly <= (m == 1) ? 4'h6 : 4'h1;
         sreq <= 1'b1;
         @(posedge clk) sreq <= 1'b0;
         repeat (30)
         begin
            #1;
            if (mi_n === 1'b0)
               break;
            if (fl_n === 1'b0)
               cnt++;
            @(posedge clk);
         end
         chk("mgmt interrupt", mi_n, 1'b0);
         if (mi_n !== 1'b0)
            test_done();
         chk("flush cycles", cnt, (m == 1) ? 0 : `SMM_FLUSH_CYCLES);
         chk("cache enable", ce_n, 1'b0);
         chk("flush released", fl_n, 1'b1);
         repeat (20)
         begin
            tick(1);
            if (mi_n === 1'b1)
               break;
         end
         chk("after ack", {fl_n, ce_n, mi_n}, 3'b111);
      end
   endtask : t_smm
   task automatic t_clk;
      logic v;
      for (int m = 0; m < 2; m++)
      begin
         wr(`CTRL3_ADDR, (m == 1) ? 8'hFF : 8'hFD);
         @(posedge clk) sclk <= 1'b1;
         pm <= (m == 1);
         tick(3);
         v = xclk;
         repeat (2)
         begin
            @(posedge clk) osc <= 1'b1;
            tick(3);
            v = !v;
            chk("osc half", xclk, v);
            @(posedge clk) osc <= 1'b0;
         end
      end
      @(posedge clk) pm <= 1'b0;
      sclk <= 1'b0;
      tick(3);
      chk("sync low", xclk, 1'b0);
      @(posedge clk) sclk <= 1'b1;
      tick(3);
      chk("sync high", xclk, 1'b1);
   endtask : t_clk
   task automatic t_hole;
      logic [1:0] k;
      wr(`HOLE1_LO_ADDR, 8'h34);
      @(posedge clk) caddr <= 11'h13A;
      for (int t = 0; t < 4; t++)
      begin
         k = t[1:0];
         wr(`HOLE1_ADDR, {k[1], 2'b11, k[0], 4'h1});
         tick(2);
         chk("hit isa", h_isa, (k == 2'b00));
         chk("hit rom", h_rom, (k == 2'b01));
         chk("hit dram", h_dram, (k == 2'b11));
      end
      wr(`HOLE1_ADDR, 8'h91);
      tick(2);
      chk("64k miss", h_dram, 1'b0);
      @(posedge clk) caddr <= 11'h137;
      wr(`HOLE1_ADDR, 8'hD1);
      tick(2);
      chk("256k hit", h_dram, 1'b1);
   endtask : t_hole
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_l2();
      t_turbo();
      t_snoop();
      t_smm();
      t_clk();
      t_hole();
      test_done();
   end
endmodule : cache_clock_hole_config_regs_tb
